//--- ahp_pkg.sv
// Shared constants for the converter host-port control design
package ahp_pkg;
	localparam int CLK_NS = 8;
	localparam int RST_NS = 100;
	localparam int TRIG_NS = 40;
	localparam int STRB_NS = 40;
	localparam int CONV_NS = 3000;
	// Least times round up to whole cycles
	localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRIG_CYC = (TRIG_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_CYC_DEF = (CONV_NS + CLK_NS - 1) / CLK_NS;
	// Data line roles
	localparam int DB_SCLK = 6;
	localparam int DB_BYTE_ORDER_SELECT = 7;
	localparam int DB_DOUT_A = 8;
	localparam int DB_DOUT_B = 9;
	localparam int DB_DOUT_C = 10;
	localparam int DB_REFBUF = 14;
	localparam logic [15:0] DB_SER_GND = 16'hb800;
	// Device control word fields
	localparam int CTL_PAIR_LSB = 5;
	localparam int CTL_RNG_LSB = 2;
	localparam int CTL_SELB = 1;
	localparam int CTL_SELC = 0;
	localparam logic [15:0] CTL_RST = 16'h0000;
	// Host register map
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0c;
	localparam int CFG_SER = 0;
	localparam int CFG_HWSW = 1;
	localparam int CFG_WB = 2;
	localparam int CFG_SPAN = 3;
	localparam int CFG_LPI = 4;
	localparam int CFG_REFBUF = 5;
	localparam int CFG_ORDER = 6;
	localparam int CFG_MASK_LSB = 8;
	localparam logic [31:0] CFG_RST = 32'h00000710;
	localparam int CMD_RST = 0;
	localparam int CMD_CONV = 1;
	localparam int CMD_READ = 2;
	localparam int CMD_WRITE = 3;
	localparam int CMD_WORD_LSB = 16;
endpackage

//--- ahp_if.sv
// Pin-level link between the converter and its host
interface ahp_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic reset;
	logic [2:0] conversion_trigger;
	logic interface_select;
	logic hw_sw_sel;
	logic word_byte;
	logic span_sel;
	logic low_power_input;
	logic busy;
	logic [15:0] db_h_o;
	logic [15:0] db_h_oe;
	logic [15:0] db_d_o;
	logic [15:0] db_d_oe;
	wire logic [15:0] db;

	// Undriven lines read low
	assign db = (db_d_o & db_d_oe) | (db_h_o & db_h_oe);

	modport dev (input cs_n, rd_n, wr_n, reset, conversion_trigger, interface_select,
		hw_sw_sel, word_byte, span_sel, low_power_input, db, output busy, db_d_o, db_d_oe);
	modport host (output cs_n, rd_n, wr_n, reset, conversion_trigger, interface_select,
		hw_sw_sel, word_byte, span_sel, low_power_input, db_h_o, db_h_oe, input busy, db);
endinterface

//--- ahp_conv_timer.sv
// Conversion timer standing in for the internal oscillator
module ahp_conv_timer #(
	parameter int CYC = 375
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic start, // Begin a conversion
	input wire logic abort, // Drop the conversion
	output logic done_q // One-cycle end pulse
);
	logic [15:0] cnt_q;
	logic run_q;

	if (CYC < 1 || CYC > 65535) begin : g_chk
		$error("CYC out of range");
	end

	// Count down; abort wins over start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (abort) begin
				run_q <= 1'b0;
			end else if (start) begin
				cnt_q <= 16'(CYC - 1);
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == 16'h0000) begin
					run_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule

//--- ahp_device.sv
// Converter end: pin roles, conversion control and parallel/serial read paths
// Functional notes
// - Serial, third enable: line 10 is output C
// - Parallel, select and read low: drive result
// - Parallel, select and write low: load control
// - Serial: host grounds lines 11,12,13,15
// - Narrow variants pad top bits with zeros
// - Serial: line 14 sets reference buffers
// - Reset input is active high
// - Software mode reset: abort, control cleared
// - Hardware mode reset: take select pin levels
// - Host pulses reset after power-up, 100 ns
// - After reset, full trigger pulse before converting
// - Trigger held high during reset
// - Hardware mode reset between conversions allowed
// - Hardware span sampled at busy falling edge
// - Software mode: span from control bits
// - Low-power input low: all converters standby
// - Select 0: trigger pins pick pairs
// - Serial: first trigger alone starts conversions
// - Word mode: sixteen lines per transfer
// - Byte mode: upper lines, line 7 order
// - Order high: high byte first, else low
// - Serial, second enable: line 9 is output B
module ahp_device import ahp_pkg::*; #(
	parameter int RES = 16,
	parameter int CONV_CYC = CONV_CYC_DEF
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	ahp_if.dev link, // Pins toward the host
	input wire logic [95:0] sample_in, // Six held samples, channel 0 lowest
	output logic standby_q, // Converters in standby
	output logic ref_buf_en_q, // Internal reference buffers on
	output logic [2:0] span_q // Per pair span, 1 = two references
);
	logic [2:0] trig_prev_q;
	logic [2:0] armed_q;
	logic [2:0] pairs_q;
	logic [2:0] rise;
	logic [2:0] go_pairs;
	logic go;
	logic done;
	logic busy_q;
	logic busy_prev_q;
	logic range_q;
	logic [15:0] ctrl_q;
	logic [15:0] samp_q [6];
	logic [15:0] res_q [6];
	logic [2:0] ch_q;
	logic byte_q;
	logic rd_prev_q;
	logic cs_prev_q;
	logic sclk_prev_q;
	logic [31:0] sh_q [3];
	logic [15:0] db_o_q;
	logic [15:0] db_oe_q;
	logic ser;
	logic sw;
	logic rst;
	logic rd_end;

	if (RES != 12 && RES != 14 && RES != 16) begin : g_chk
		$error("RES must be 12, 14 or 16");
	end

	// Keep the top RES bits of a sample, zeros above
	function automatic logic [15:0] pad(input logic [15:0] s);
		pad = s >> (16 - RES);
	endfunction

	assign ser = link.interface_select;
	assign sw = link.hw_sw_sel;
	assign rst = link.reset;
	assign rise = ~trig_prev_q & link.conversion_trigger;
	assign rd_end = !rd_prev_q && link.rd_n && !cs_prev_q;
	assign link.busy = busy_q;
	assign link.db_d_o = db_o_q;
	assign link.db_d_oe = db_oe_q;

	// Pair choice and start; standby and a running conversion block new starts
	always_comb begin
		if (sw || ser) begin
			go_pairs = (rise[0] && armed_q[0]) ? 3'b111 : 3'b000;
			if (sw) begin
				go_pairs = go_pairs & ctrl_q[CTL_PAIR_LSB +: 3];
			end
		end else begin
			go_pairs = rise & armed_q;
		end
		go = (|go_pairs) && !busy_q && !rst && link.low_power_input;
	end

	ahp_conv_timer #(.CYC(CONV_CYC)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(go),
		.abort(rst),
		.done_q(done)
	);

	// A trigger falling edge arms its pair; reset disarms all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_q <= 3'b111;
			armed_q <= 3'b000;
		end else begin
			trig_prev_q <= link.conversion_trigger;
			if (rst) begin
				armed_q <= 3'b000;
			end else begin
				armed_q <= (armed_q | (trig_prev_q & ~link.conversion_trigger)) & ~go_pairs;
			end
		end
	end

	// Busy and track-and-hold; reset aborts in either mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			busy_prev_q <= 1'b0;
			pairs_q <= 3'b000;
		end else begin
			busy_prev_q <= busy_q;
			if (rst) begin
				busy_q <= 1'b0;
			end else if (go) begin
				busy_q <= 1'b1;
				pairs_q <= go_pairs;
			end else if (done) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Samples held at start, results published at end of busy
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 6; i++) begin
			if (go && go_pairs[i / 2]) begin
				samp_q[i] <= sample_in[16 * i +: 16];
			end
			if (done && pairs_q[i / 2]) begin
				res_q[i] <= pad(samp_q[i]);
			end
		end
	end

	// Hardware span: pin level caught at reset or at busy falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_q <= 1'b0;
		end else if (rst && !sw) begin
			range_q <= link.span_sel;
		end else if (busy_prev_q && !busy_q && !sw) begin
			range_q <= link.span_sel;
		end
	end

	// Control word written while select and write strobe are low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTL_RST;
		end else if (rst && sw) begin
			ctrl_q <= CTL_RST;
		end else if (!ser && !link.cs_n && !link.wr_n) begin
			ctrl_q <= link.db;
		end
	end

	// Block-level status outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_q <= 1'b0;
			ref_buf_en_q <= 1'b1;
			span_q <= 3'b000;
		end else begin
			standby_q <= !link.low_power_input;
			ref_buf_en_q <= ser ? link.db[DB_REFBUF] : 1'b1;
			span_q <= sw ? ctrl_q[CTL_RNG_LSB +: 3] : {3{range_q}};
		end
	end

	// Read pointer: one step per word, or per second byte in byte mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
			ch_q <= 3'd0;
			byte_q <= 1'b0;
		end else begin
			rd_prev_q <= link.rd_n;
			cs_prev_q <= link.cs_n;
			if (done || rst) begin
				ch_q <= 3'd0;
				byte_q <= 1'b0;
			end else if (rd_end && !ser) begin
				if (link.word_byte && !byte_q) begin
					byte_q <= 1'b1;
				end else begin
					byte_q <= 1'b0;
					ch_q <= (ch_q == 3'd5) ? 3'd0 : ch_q + 3'd1;
				end
			end
		end
	end

	// Serial shifters: loaded when select falls, shifted on clock falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev_q <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				sh_q[k] <= 32'h00000000;
			end
		end else begin
			sclk_prev_q <= link.db[DB_SCLK];
			for (int k = 0; k < 3; k++) begin
				if (ser && cs_prev_q && !link.cs_n) begin
					sh_q[k] <= {res_q[2 * k], res_q[2 * k + 1]};
				end else if (ser && !link.cs_n && sclk_prev_q && !link.db[DB_SCLK]) begin
					sh_q[k] <= {sh_q[k][30:0], 1'b0};
				end
			end
		end
	end

	// Data line drive, registered; line 7 is left to the host in byte mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db_o_q <= 16'h0000;
			db_oe_q <= 16'h0000;
		end else begin
			db_o_q <= 16'h0000;
			db_oe_q <= 16'h0000;
			if (!ser && !link.cs_n && !link.rd_n && !link.word_byte) begin
				db_o_q <= res_q[ch_q];
				db_oe_q <= 16'hffff;
			end else if (!ser && !link.cs_n && !link.rd_n) begin
				if (link.db[DB_BYTE_ORDER_SELECT] ^ byte_q) begin
					db_o_q <= {res_q[ch_q][15:8], 8'h00};
				end else begin
					db_o_q <= {res_q[ch_q][7:0], 8'h00};
				end
				db_oe_q <= 16'hff00;
			end else if (ser && !link.cs_n) begin
				db_o_q[DB_DOUT_A] <= sh_q[0][31];
				db_o_q[DB_DOUT_B] <= sh_q[1][31];
				db_o_q[DB_DOUT_C] <= sh_q[2][31];
				db_oe_q[DB_DOUT_A] <= 1'b1;
				db_oe_q[DB_DOUT_B] <= ctrl_q[CTL_SELB];
				db_oe_q[DB_DOUT_C] <= ctrl_q[CTL_SELC];
			end
		end
	end
endmodule

//--- ahp_host.sv
// Host end: APB register file driving reset, trigger, read and write sequences
module ahp_host import ahp_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata_q, // APB read data
	output logic pready_q, // APB ready
	output logic pslverr_q, // APB error on unmapped address
	ahp_if.host link // Pins toward the converter
);
	typedef enum logic [2:0] {H_IDLE, H_RST, H_TLO, H_RD, H_RDGAP, H_WR} ahp_hst_t;
	ahp_hst_t st_q;
	logic [31:0] cfg_q;
	logic [3:0] cmd_q;
	logic [15:0] wword_q;
	logic [15:0] data_q;
	logic [7:0] cnt_q;
	logic second_q;
	logic cs_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic rst_q;
	logic [2:0] trig_q;
	logic [15:0] db_o_q;
	logic [15:0] db_oe_q;
	logic wr_acc;
	logic mapped;

	assign wr_acc = psel && penable && pready_q && pwrite;
	assign mapped = paddr == REG_CFG || paddr == REG_CMD || paddr == REG_STAT
		|| paddr == REG_DATA;
	assign link.cs_n = cs_n_q;
	assign link.rd_n = rd_n_q;
	assign link.wr_n = wr_n_q;
	assign link.reset = rst_q;
	assign link.conversion_trigger = trig_q;
	assign link.interface_select = cfg_q[CFG_SER];
	assign link.hw_sw_sel = cfg_q[CFG_HWSW];
	assign link.word_byte = cfg_q[CFG_WB];
	assign link.span_sel = cfg_q[CFG_SPAN];
	assign link.low_power_input = cfg_q[CFG_LPI];
	assign link.db_h_o = db_o_q;
	assign link.db_h_oe = db_oe_q;

	// APB answer prepared in the setup cycle, so every access takes one wait-free phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			case (paddr)
				REG_CFG: prdata_q <= cfg_q;
				REG_STAT: prdata_q <= {30'h00000000, st_q != H_IDLE, link.busy};
				REG_DATA: prdata_q <= {16'h0000, data_q};
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	// Configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CFG_RST;
		end else if (wr_acc && paddr == REG_CFG) begin
			cfg_q <= pwdata;
		end
	end

	// Sequencer: commands taken only when idle, others are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= H_IDLE;
			cmd_q <= 4'h0;
			wword_q <= 16'h0000;
			data_q <= 16'h0000;
			cnt_q <= 8'h00;
			second_q <= 1'b0;
			cs_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			rst_q <= 1'b0;
			trig_q <= 3'b111;
		end else begin
			if (wr_acc && paddr == REG_CMD && st_q == H_IDLE && cmd_q == 4'h0) begin
				cmd_q <= pwdata[3:0];
				wword_q <= pwdata[CMD_WORD_LSB +: 16];
			end
			case (st_q)
				H_IDLE: begin
					if (cmd_q[CMD_RST]) begin
						cmd_q[CMD_RST] <= 1'b0;
						rst_q <= 1'b1;
						trig_q <= 3'b111;
						cnt_q <= 8'(RST_CYC - 1);
						st_q <= H_RST;
					end else if (cmd_q[CMD_WRITE]) begin
						cmd_q[CMD_WRITE] <= 1'b0;
						cs_n_q <= 1'b0;
						wr_n_q <= 1'b0;
						cnt_q <= 8'(STRB_CYC - 1);
						st_q <= H_WR;
					end else if (cmd_q[CMD_CONV]) begin
						cmd_q[CMD_CONV] <= 1'b0;
						trig_q <= ~cfg_q[CFG_MASK_LSB +: 3];
						cnt_q <= 8'(TRIG_CYC - 1);
						st_q <= H_TLO;
					end else if (cmd_q[CMD_READ]) begin
						cmd_q[CMD_READ] <= 1'b0;
						cs_n_q <= 1'b0;
						rd_n_q <= 1'b0;
						second_q <= 1'b0;
						cnt_q <= 8'(STRB_CYC - 1);
						st_q <= H_RD;
					end
				end
				H_RST: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						rst_q <= 1'b0;
						st_q <= H_IDLE;
					end
				end
				H_TLO: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						trig_q <= 3'b111;
						st_q <= H_IDLE;
					end
				end
				H_RD: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						rd_n_q <= 1'b1;
						if (!cfg_q[CFG_WB]) begin
							data_q <= link.db;
							cs_n_q <= 1'b1;
							st_q <= H_IDLE;
						end else if (!second_q) begin
							// First byte lands by the order pin
							if (cfg_q[CFG_ORDER]) begin
								data_q[15:8] <= link.db[15:8];
							end else begin
								data_q[7:0] <= link.db[15:8];
							end
							cnt_q <= 8'(STRB_CYC - 1);
							st_q <= H_RDGAP;
						end else begin
							if (cfg_q[CFG_ORDER]) begin
								data_q[7:0] <= link.db[15:8];
							end else begin
								data_q[15:8] <= link.db[15:8];
							end
							cs_n_q <= 1'b1;
							st_q <= H_IDLE;
						end
					end
				end
				H_RDGAP: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						rd_n_q <= 1'b0;
						second_q <= 1'b1;
						cnt_q <= 8'(STRB_CYC - 1);
						st_q <= H_RD;
					end
				end
				H_WR: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						cs_n_q <= 1'b1;
						wr_n_q <= 1'b1;
						st_q <= H_IDLE;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	// Background line drive: ground and buffer pin in serial, order pin in byte mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db_o_q <= 16'h0000;
			db_oe_q <= 16'h0000;
		end else if (st_q == H_WR) begin
			db_o_q <= wword_q;
			db_oe_q <= 16'hffff;
		end else if (cfg_q[CFG_SER]) begin
			db_o_q <= {1'b0, cfg_q[CFG_REFBUF], 14'h0000};
			db_oe_q <= DB_SER_GND | 16'h4000;
		end else if (cfg_q[CFG_WB]) begin
			db_o_q <= {8'h00, cfg_q[CFG_ORDER], 7'h00};
			db_oe_q <= 16'h0080;
		end else begin
			db_o_q <= 16'h0000;
			db_oe_q <= 16'h0000;
		end
	end
endmodule

//--- ahp_link_sva.sv
// Concurrent checks on the pin link between converter and host
module ahp_link_sva import ahp_pkg::*; #(
	parameter int CONV_CYC = CONV_CYC_DEF
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic cs_n, // Device select
	input wire logic rd_n, // Read strobe
	input wire logic reset, // Link reset, active high
	input wire logic [2:0] conversion_trigger, // Triggers, idle high
	input wire logic interface_select, // 1 serial
	input wire logic hw_sw_sel, // 0 hardware mode
	input wire logic low_power_input, // 0 standby
	input wire logic busy, // Conversion running
	input wire logic [15:0] db_h_oe, // Host drive enables
	input wire logic [15:0] db_d_oe, // Device drive enables
	input wire logic [15:0] db // Resolved data lines
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	localparam int BUSY_MAX = 1000;
	logic [15:0] busy_len_q;

	// Busy length counter; cleared while busy is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_len_q <= 16'h0000;
		end else if (busy) begin
			busy_len_q <= busy_len_q + 16'h0001;
		end else begin
			busy_len_q <= 16'h0000;
		end
	end

	// Parallel read strobe held long enough for the registered drive
	sequence rd_held;
		(!interface_select && !cs_n && !rd_n)[*3];
	endsequence
	// Hardware mode trigger rise the device must accept
	sequence trig_rise;
		$rose(conversion_trigger[0]) && !hw_sw_sel && low_power_input && !reset && !busy;
	endsequence

	chk_read_drive: assert property (rd_held |-> db_d_oe[15:8] == 8'hff)
		else $error("device not driving result during read");
	chk_read_release: assert property ((!interface_select && cs_n)[*3] |-> db_d_oe == 16'h0000)
		else $error("device drives lines while deselected");
	chk_no_fight: assert property ((db_d_oe & db_h_oe) == 16'h0000)
		else $error("both ends drive the same line");
	chk_trig_in_reset: assert property (reset |-> conversion_trigger == 3'b111)
		else $error("trigger low during link reset");
	chk_reset_width: assert property ($rose(reset) |-> reset[*8] ##[1:12] !reset)
		else $error("link reset pulse width wrong");
	chk_busy_start: assert property (trig_rise |-> ##[1:3] busy)
		else $error("busy did not follow trigger rise");
	chk_busy_len: assert property ($fell(busy) && !$past(reset) && !$past(reset, 2)
		|-> busy_len_q >= CONV_CYC - 1 && busy_len_q <= CONV_CYC + 1)
		else $error("busy length differs from conversion time");
	chk_busy_bound: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
		else $error("busy never fell");
	chk_standby_idle: assert property (!low_power_input && $past(!low_power_input)
		&& !$past(busy) |-> !busy)
		else $error("conversion started in standby");
	chk_ser_ground: assert property (interface_select && $past(interface_select)
		|-> (db & 16'hb800) == 16'h0000)
		else $error("unused upper lines not at ground in serial mode");
endmodule

//--- adc_host_port_control_tb_top.sv
// Self-checking bench for the converter and host pair joined by the pin link
module adc_host_port_control_tb_top import ahp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CONV_LEN = 40;
	typedef struct packed {
		logic [31:0] cfg;
		logic [15:0] exp;
	} ahp_row_t;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [95:0] sample_in;
	logic standby_q;
	logic ref_buf_en_q;
	logic [2:0] span_q;
	logic [31:0] rd_data;
	logic rd_err;
	logic seen;
	int fail_count;
	int samples_checked;
	ahp_row_t rows [6];

	ahp_if link_if();
	ahp_device #(.RES(16), .CONV_CYC(CONV_LEN)) u_ahp_device (.pclk(pclk), .presetn(presetn),
		.link(link_if), .sample_in(sample_in), .standby_q(standby_q),
		.ref_buf_en_q(ref_buf_en_q), .span_q(span_q));
	ahp_host u_ahp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .link(link_if));
	ahp_link_sva #(.CONV_CYC(CONV_LEN)) u_ahp_link_sva (.pclk(pclk), .presetn(presetn),
		.cs_n(link_if.cs_n), .rd_n(link_if.rd_n), .reset(link_if.reset),
		.conversion_trigger(link_if.conversion_trigger),
		.interface_select(link_if.interface_select), .hw_sw_sel(link_if.hw_sw_sel),
		.low_power_input(link_if.low_power_input), .busy(link_if.busy),
		.db_h_oe(link_if.db_h_oe), .db_d_oe(link_if.db_d_oe), .db(link_if.db));

	// Free-running 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Watchdog well beyond the expected run of several hundred cycles
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; ends with an idle edge so the next setup never collides
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 100);
		if (pready_q !== 1'b1) fail_count++;
		rd_data = prdata_q;
		rd_err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Poll the sequencer busy flag, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h00000000);
			n++;
		end while (rd_data[1] !== 1'b0 && n < 200);
		if (rd_data[1] !== 1'b0) fail_count++;
	endtask

	task automatic cmd(input logic [3:0] bits, input logic [15:0] word);
		apb(1'b1, REG_CMD, {word, 12'h000, bits});
		wait_idle();
	endtask

	// Convert, then watch busy; a refused trigger leaves it low all window
	task automatic conv(input logic run);
		int n;
		n = 0;
		seen = 1'b0;
		apb(1'b1, REG_CMD, 32'h00000002);
		while (n < 100 && !(seen && link_if.busy === 1'b0)) begin
			@(posedge pclk);
			n++;
			if (link_if.busy === 1'b1) seen = 1'b1;
		end
		chk_pin({2'b00, seen}, {2'b00, run});
		wait_idle();
	endtask

	initial begin
		int n;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		fail_count = 0;
		samples_checked = 0;
		sample_in = {16'hff00, 16'h00ff, 16'hcdef, 16'h1234, 16'h7ffe, 16'h8001};
		rows = '{'{32'h0000071a, 16'h8001}, '{32'h0000075e, 16'h7ffe},
			'{32'h0000071e, 16'h1234}, '{32'h0000071a, 16'hcdef},
			'{32'h0000075e, 16'h00ff}, '{32'h0000071e, 16'hff00}};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, write-only readback and an unmapped address
		apb(1'b0, REG_CFG, 32'h00000000);
		chk_reg(rd_data, 32'h00000710);
		apb(1'b0, REG_CMD, 32'h00000000);
		chk_reg(rd_data, 32'h00000000);
		chk_pin({standby_q, ref_buf_en_q, 1'b0}, 3'b010);
		chk_pin(span_q, 3'b000);
		apb(1'b0, 8'h10, 32'h00000000);
		chk_pin({2'b00, rd_err}, 3'b001);
		// Power-up pulse, then software mode with all pairs and spans loaded
		cmd(4'h1, 16'h0000);
		apb(1'b1, REG_CFG, 32'h0000071a);
		cmd(4'h8, 16'h00f4);
		chk_pin(span_q, 3'b101);
		conv(1'b1);
		chk_pin(span_q, 3'b101);
		// Six reads of one conversion in word and both byte orders
		foreach (rows[i]) begin
			apb(1'b1, REG_CFG, rows[i].cfg);
			cmd(4'h4, 16'h0000);
			apb(1'b0, REG_DATA, 32'h00000000);
			chk_reg(rd_data, {16'h0000, rows[i].exp});
		end
		// Link reset in mid-conversion aborts it and clears the control word
		apb(1'b1, REG_CMD, 32'h00000002);
		n = 0;
		while (link_if.busy !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		apb(1'b0, REG_STAT, 32'h00000000);
		chk_pin({2'b00, rd_data[0]}, 3'b001);
		apb(1'b1, REG_CMD, 32'h00000001);
		n = 0;
		while (link_if.reset !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		repeat (3) @(posedge pclk);
		chk_pin({2'b00, link_if.busy}, 3'b000);
		wait_idle();
		chk_pin(span_q, 3'b000);
		// Hardware mode: span taken at busy fall and at link reset
		apb(1'b1, REG_CFG, 32'h00000718);
		conv(1'b1);
		chk_pin(span_q, 3'b111);
		apb(1'b1, REG_CFG, 32'h00000710);
		chk_pin(span_q, 3'b111);
		conv(1'b1);
		chk_pin(span_q, 3'b000);
		apb(1'b1, REG_CFG, 32'h00000718);
		cmd(4'h1, 16'h0000);
		chk_pin(span_q, 3'b111);
		// Standby refuses a trigger
		apb(1'b1, REG_CFG, 32'h00000708);
		apb(1'b0, REG_CFG, 32'h00000000);
		chk_pin({2'b00, standby_q}, 3'b001);
		conv(1'b0);
		apb(1'b1, REG_CFG, 32'h00000718);
		apb(1'b0, REG_CFG, 32'h00000000);
		chk_pin({2'b00, standby_q}, 3'b000);
		// Control word with output B on and C off, loaded while still parallel
		apb(1'b1, REG_CFG, 32'h0000071a);
		cmd(4'h8, 16'h00e2);
		// Serial mode: line 14 steers the reference buffers, first trigger converts
		apb(1'b1, REG_CFG, 32'h00000731);
		apb(1'b0, REG_CFG, 32'h00000000);
		chk_reg(rd_data, 32'h00000731);
		chk_pin({2'b00, ref_buf_en_q}, 3'b001);
		apb(1'b1, REG_CFG, 32'h00000711);
		apb(1'b0, REG_CFG, 32'h00000000);
		chk_pin({2'b00, ref_buf_en_q}, 3'b000);
		conv(1'b1);
		// Serial select low: line 8 always, line 9 enabled, line 10 held off
		apb(1'b1, REG_CMD, 32'h00000004);
		repeat (3) @(posedge pclk);
		chk_pin(link_if.db_d_oe[10:8], 3'b011);
		wait_idle();
		wrap_up();
	end
endmodule
